// ===== startup_pkg.sv
`default_nettype none
package startup_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int N_BUCK      = 4;
  localparam int N_LDO       = 6;
  localparam int N_OUT       = N_BUCK + N_LDO + 1;
  localparam int SLOT_W      = 5;
  localparam int UNIT_W      = 14;
  localparam int FUSE_W      = 69;
  localparam int FUSE_BITS_N = 4;
  localparam int CFG_W       = 61;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int BASE_TICK_US   = 500;
  localparam int BASE_TICK_CYC  = BASE_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int SLOT_US [4]    = '{500, 1000, 2000, 4000};
  localparam int FIRST_US [4]   = '{2000, 2500, 4000, 7000};
  localparam int RESET_REL_US   = 2000;
  localparam int STBY_COIN_US   = 5000;
  localparam int STBY_NOCOIN_US = 24000;
  localparam int HOLD_OFF_US    = 4000000;

  typedef logic [UNIT_W-1:0] units_t;
  typedef logic [SLOT_W-1:0] slot_t;

  localparam units_t REL_UNITS    = units_t'(RESET_REL_US / BASE_TICK_US);
  localparam units_t STBY_COIN_U  = units_t'(STBY_COIN_US / BASE_TICK_US);
  localparam units_t STBY_NOCOIN_U = units_t'(STBY_NOCOIN_US / BASE_TICK_US);
  localparam units_t HOLD_UNITS   = units_t'(HOLD_OFF_US / BASE_TICK_US);
  localparam logic [3:0] ADDR_HI  = 4'h1;

  // ----------------------------------------------------------------
  // configuration image
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [N_BUCK-1:0][SLOT_W-1:0] buck_slot_code;
    logic [N_LDO-1:0][SLOT_W-1:0]  ldo_slot_code;
    logic [SLOT_W-1:0]             ddr_ref_slot_code;
    logic [1:0]                    seq_tick_select;
    logic                          button_mode_select;
    logic [2:0]                    target_addr_bits;
  } shadow_cfg_t;

  localparam shadow_cfg_t DEFAULT_CFG = '{
    buck_slot_code:     {5'h03, 5'h03, 5'h02, 5'h01},
    ldo_slot_code:      {5'h03, 5'h03, 5'h03, 5'h00, 5'h02, 5'h00},
    ddr_ref_slot_code:  5'h03,
    seq_tick_select:    2'h1,
    button_mode_select: 1'h0,
    target_addr_bits:   3'h0
  };

  typedef enum logic [2:0] {ST_OFF, ST_PRE, ST_SEQ, ST_REL, ST_RUN} seq_state_t;

  function automatic units_t slot_units(input logic [1:0] sel);
    return units_t'(SLOT_US[sel] / BASE_TICK_US);
  endfunction : slot_units

  function automatic units_t pre_units(input logic [1:0] sel);
    return units_t'((FIRST_US[sel] - SLOT_US[sel]) / BASE_TICK_US);
  endfunction : pre_units
endpackage : startup_pkg
`default_nettype wire

// ===== pin_sync.sv
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ===== slot_gate.sv
`default_nettype none
module slot_gate
  import startup_pkg::*;
(
  input  wire logic [SLOT_W-1:0] code,
  input  wire logic [SLOT_W-1:0] slot_now,
  output logic                   en
);
  // a zero code never enables; equal codes open on the same tick
  assign en = (code != '0) && (code <= slot_now);
endmodule : slot_gate
`default_nettype wire

// ===== startup_sequencer.sv
// How it works
// - every output owns a five-bit slot code
// - zero code keeps output out and off
// - code n enables after n ticks
// - tick select picks 500/1000/2000/4000 us
// - sequence ends at highest programmed slot
// - first enable 2.0/2.5/4.0/7.0 ms
// - host reset released 2.0 ms after last
// - standby on 5 ms, 24 ms without cell
// - level mode: pin high on, low off
// - edge mode: fall on, 4 s low off
// - target address 0x08 plus three bits
// - fuse ecc fixes one, flags two
// - shadow cleared on first main supply
// - source pin high loads built-in defaults
// - fuses load only with all load bits
// - no source keeps shadow zero, no sequence
// - keep flag resets low, blocks fuse loads
// - power up needs supply and turn-on
// - fed linear waits for its buck
`default_nettype none
module startup_sequencer
  import startup_pkg::*;
#(
  parameter int                   BASE_CYC      = BASE_TICK_CYC,
  parameter logic [N_LDO-1:0]     LDO_FED       = '0,
  parameter logic [N_LDO*2-1:0]   LDO_FEED_BUCK = '0
) (
  input  wire logic                   CLK,
  input  wire logic                   NRST,
  input  wire logic                   CE,
  input  wire logic                   MAIN_SUPPLY_VALID,
  input  wire logic                   COIN_CELL_VALID,
  input  wire logic                   CONFIG_SOURCE_PIN,
  input  wire logic                   POWER_ON_PIN,
  input  wire logic                   KEEP_WR,
  input  wire logic                   KEEP_WDATA,
  input  wire logic                   SHADOW_WR,
  input  wire shadow_cfg_t            SHADOW_WDATA,
  input  wire logic                   FUSE_LOAD_REQUEST,
  input  wire logic [FUSE_BITS_N-1:0] FUSE_LOAD_BITS,
  input  wire logic                   FUSE_ECC_EN,
  input  wire logic [FUSE_W-1:0]      FUSE_WORD,
  output logic      [N_BUCK-1:0]      BUCK_EN,
  output logic      [N_LDO-1:0]       LDO_EN,
  output logic                        DDR_REF_EN,
  output logic                        STANDBY_EN,
  output logic                        HOST_RESET_N_OUT,
  output logic                        HOST_RESET_N_OE,
  output logic      [6:0]             TARGET_ADDR,
  output shadow_cfg_t                 SHADOW_CFG,
  output logic                        KEEP_SHADOW_FLAG,
  output logic                        FUSE_ERR_FIXED,
  output logic                        FUSE_ERR_MULTI,
  output logic                        SEQ_BUSY
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic       main_s;
  logic       coin_s;
  logic       src_s;
  logic       pin_s;

  pin_sync #(.W(4)) u_sync (
    .clk   (CLK),
    .rst_n (NRST),
    .ce    (CE),
    .d     ({MAIN_SUPPLY_VALID, COIN_CELL_VALID, CONFIG_SOURCE_PIN, POWER_ON_PIN}),
    .q     (pins_s)
  );

  assign main_s = pins_s[3];
  assign coin_s = pins_s[2];
  assign src_s  = pins_s[1];
  assign pin_s  = pins_s[0];

  // ----------------------------------------------------------------
  // fuse error correction
  // ----------------------------------------------------------------
  function automatic logic [CFG_W+1:0] ecc_fix(input logic [FUSE_W-1:0] w, input logic en);
    logic [6:0]        syn;
    logic              par;
    logic              fixed;
    logic              multi;
    logic [FUSE_W-1:0] c;
    logic [CFG_W-1:0]  d;
    int                k;
    syn   = '0;
    par   = ^w;
    c     = w;
    fixed = 1'b0;
    multi = 1'b0;
    d     = '0;
    k     = 0;
    for (int p = 1; p < FUSE_W; p++) begin
      if (w[p]) begin
        syn = syn ^ 7'(p);
      end
    end
    if (en) begin
      if (par && (int'(syn) < FUSE_W)) begin
        c[syn] = ~c[syn];
        fixed  = 1'b1;
      end else if (par || (syn != '0)) begin
        multi = 1'b1;
      end
    end
    for (int p = 1; p < FUSE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = c[p];
        k    = k + 1;
      end
    end
    return {multi, fixed, d};
  endfunction : ecc_fix

  logic [CFG_W+1:0] ecc_out;
  shadow_cfg_t      fuse_cfg;

  assign ecc_out  = ecc_fix(FUSE_WORD, FUSE_ECC_EN);
  assign fuse_cfg = shadow_cfg_t'(ecc_out[CFG_W-1:0]);

  // ----------------------------------------------------------------
  // shadow configuration and source selection
  // ----------------------------------------------------------------
  shadow_cfg_t shadow;
  shadow_cfg_t loaded_cfg;
  logic        keep_flag;
  logic        main_seen;
  logic        load_pending;
  logic        first_valid;
  logic        fuse_ok;
  logic        do_load;
  logic        turn_on;
  logic        turn_off;

  assign first_valid = main_s & ~main_seen;
  assign fuse_ok     = FUSE_LOAD_REQUEST & (&FUSE_LOAD_BITS);
  assign loaded_cfg  = src_s ? DEFAULT_CFG : fuse_cfg;
  assign do_load     = (load_pending | turn_on)
                       & (src_s | (~keep_flag & fuse_ok));

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      shadow         <= '0;
      keep_flag      <= 1'b0;
      main_seen      <= 1'b0;
      load_pending   <= 1'b0;
      FUSE_ERR_FIXED <= 1'b0;
      FUSE_ERR_MULTI <= 1'b0;
    end else if (CE) begin
      // a supply that returns after a loss counts as newly applied
      main_seen    <= main_s;
      load_pending <= first_valid;
      if (first_valid) begin
        shadow    <= '0;
        keep_flag <= 1'b0;
      end else if (do_load) begin
        shadow         <= loaded_cfg;
        FUSE_ERR_FIXED <= ~src_s & ecc_out[CFG_W];
        FUSE_ERR_MULTI <= ~src_s & ecc_out[CFG_W+1];
      end else if (SHADOW_WR && main_s) begin
        shadow <= SHADOW_WDATA;
      end
      if (!first_valid && KEEP_WR && main_s) begin
        keep_flag <= KEEP_WDATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // base tick, slot codes
  // ----------------------------------------------------------------
  logic [31:0]      cyc_cnt;
  logic             unit_tick;
  slot_t            codes [N_OUT];
  slot_t            max_slot;
  logic [N_OUT-1:0] gate_en;
  units_t           slot_len;
  units_t           pre_len;

  assign unit_tick = (cyc_cnt == 32'(BASE_CYC - 1));
  assign slot_len  = slot_units(shadow.seq_tick_select);
  assign pre_len   = pre_units(shadow.seq_tick_select);

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cyc_cnt <= '0;
    end else if (CE) begin
      cyc_cnt <= (unit_tick || turn_on) ? '0 : cyc_cnt + 32'h1;
    end
  end

  for (genvar i = 0; i < N_BUCK; i++) begin : g_buck
    assign codes[i] = shadow.buck_slot_code[i];
  end
  for (genvar i = 0; i < N_LDO; i++) begin : g_ldo
    assign codes[N_BUCK+i] = shadow.ldo_slot_code[i];
  end
  assign codes[N_OUT-1] = shadow.ddr_ref_slot_code;

  always_comb begin
    max_slot = '0;
    for (int i = 0; i < N_OUT; i++) begin
      if (codes[i] > max_slot) begin
        max_slot = codes[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // turn-on and turn-off events
  // ----------------------------------------------------------------
  seq_state_t state;
  seq_state_t next_state;
  units_t     unit_cnt;
  units_t     next_unit;
  slot_t      slot_cnt;
  slot_t      next_slot;
  units_t     hold_cnt;
  logic       pin_prev;
  logic       pin_fall;
  logic       on_req;

  assign pin_fall = pin_prev & ~pin_s;
  assign on_req   = shadow.button_mode_select ? pin_fall : pin_s;
  assign turn_on  = (state == ST_OFF) & main_s & on_req;
  assign turn_off = (state != ST_OFF)
                    & (~main_s
                       | (shadow.button_mode_select ? (hold_cnt >= HOLD_UNITS)
                                                    : ~pin_s));

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pin_prev <= 1'b0;
      hold_cnt <= '0;
    end else if (CE) begin
      pin_prev <= pin_s;
      if (pin_s || state == ST_OFF) begin
        hold_cnt <= '0;
      end else if (unit_tick && hold_cnt < HOLD_UNITS) begin
        hold_cnt <= hold_cnt + units_t'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_slot  = slot_cnt;
    next_unit  = unit_tick ? unit_cnt + units_t'(1) : unit_cnt;
    case (state)
      ST_OFF: begin
        next_unit = '0;
        next_slot = '0;
        if (turn_on) begin
          next_state = ST_PRE;
        end
      end
      ST_PRE: begin
        if (unit_tick && next_unit == pre_len) begin
          next_unit  = '0;
          next_state = (max_slot == '0) ? ST_OFF : ST_SEQ;
        end
      end
      ST_SEQ: begin
        if (unit_tick && next_unit == slot_len) begin
          next_unit = '0;
          next_slot = slot_cnt + slot_t'(1);
          if (next_slot >= max_slot) begin
            next_state = ST_REL;
          end
        end
      end
      ST_REL: begin
        if (unit_tick && next_unit == REL_UNITS) begin
          next_unit  = '0;
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_unit = '0;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    if (turn_off) begin
      next_state = ST_OFF;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state    <= ST_OFF;
      unit_cnt <= '0;
      slot_cnt <= '0;
    end else if (CE) begin
      state    <= next_state;
      unit_cnt <= next_unit;
      slot_cnt <= next_slot;
    end
  end

  // ----------------------------------------------------------------
  // output enables
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N_OUT; i++) begin : g_gate
    slot_gate u_gate (
      .code     (codes[i]),
      .slot_now (slot_cnt),
      .en       (gate_en[i])
    );
  end

  logic [N_LDO-1:0] ldo_gated;
  for (genvar i = 0; i < N_LDO; i++) begin : g_feed
    assign ldo_gated[i] = gate_en[N_BUCK+i]
                          & (~LDO_FED[i] | gate_en[LDO_FEED_BUCK[2*i +: 2]]);
  end

  units_t stby_cnt;
  units_t stby_lim;

  assign stby_lim = coin_s ? STBY_COIN_U : STBY_NOCOIN_U;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      BUCK_EN         <= '0;
      LDO_EN          <= '0;
      DDR_REF_EN      <= 1'b0;
      HOST_RESET_N_OE <= 1'b1;
      STANDBY_EN      <= 1'b0;
      stby_cnt        <= '0;
      TARGET_ADDR     <= '0;
    end else if (CE) begin
      BUCK_EN         <= gate_en[N_BUCK-1:0];
      LDO_EN          <= ldo_gated;
      DDR_REF_EN      <= gate_en[N_OUT-1];
      HOST_RESET_N_OE <= (next_state != ST_RUN);
      TARGET_ADDR     <= {ADDR_HI, shadow.target_addr_bits};
      if (!main_s) begin
        stby_cnt   <= '0;
        STANDBY_EN <= 1'b0;
      end else if (stby_cnt >= stby_lim) begin
        STANDBY_EN <= 1'b1;
      end else if (unit_tick) begin
        stby_cnt <= stby_cnt + units_t'(1);
      end
    end
  end

  assign HOST_RESET_N_OUT = 1'b0;
  assign SHADOW_CFG       = shadow;
  assign KEEP_SHADOW_FLAG = keep_flag;
  assign SEQ_BUSY         = (state == ST_PRE) || (state == ST_SEQ) || (state == ST_REL);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence pre_done_s;
    CE && state == ST_PRE && unit_tick && next_unit == pre_len && !turn_off && max_slot != '0;
  endsequence

  zero_slot_off_a: assert property (CE && codes[0] == '0 |=> !BUCK_EN[0])
    else $error("zero slot code enabled an output");
  slot_match_a: assert property ($rose(BUCK_EN[0]) |-> $past(slot_cnt) == $past(codes[0]))
    else $error("output enabled on wrong slot");
  pre_to_seq_a: assert property (pre_done_s |=> state == ST_SEQ && slot_cnt == '0)
    else $error("first tick delay not followed by slots");
  seq_end_a: assert property (state == ST_REL |-> slot_cnt == max_slot)
    else $error("sequence ended away from highest slot");
  release_a: assert property ($fell(HOST_RESET_N_OE) |-> state == ST_RUN && $past(state) == ST_REL)
    else $error("host reset released outside sequence end");
  ldo_feed_a: assert property (LDO_FED[0] && LDO_EN[0] |-> BUCK_EN[LDO_FEED_BUCK[1:0]])
    else $error("fed linear up before its buck");
  addr_range_a: assert property (CE |=> TARGET_ADDR[6:3] == ADDR_HI)
    else $error("target address outside range");
  first_clear_a: assert property (CE && first_valid |=> shadow == '0 && !keep_flag)
    else $error("shadow not cleared on first supply");
  default_load_a: assert property (CE && do_load && src_s && !first_valid |=> shadow == DEFAULT_CFG)
    else $error("defaults not loaded");
  level_off_a: assert property (CE && !shadow.button_mode_select && !pin_s && state != ST_OFF
                                |=> state == ST_OFF)
    else $error("level low did not turn off");
endmodule : startup_sequencer
`default_nettype wire

// ===== host_model.sv
`default_nettype none
module host_model
  import startup_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  main_ok,
  output logic       power_on_pin,
  output logic       keep_wr,
  output logic       keep_wdata,
  output logic       shadow_wr,
  output shadow_cfg_t shadow_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    power_on_pin = 1'b0;
    keep_wr = 1'b0;
    keep_wdata = 1'b0;
    shadow_wr = 1'b0;
    shadow_wdata = '0;
  end

  // ----------------------------------------------------------------
  // host writes, one-cycle strobes launched at the falling edge
  // ----------------------------------------------------------------
  task automatic write_shadow(input shadow_cfg_t c);
    if (main_ok !== 1'b1) return;
    @(negedge clk);
    shadow_wr = 1'b1;
    shadow_wdata = c;
    @(negedge clk);
    shadow_wr = 1'b0;
    shadow_wdata = ~c;
  endtask : write_shadow

  task automatic write_keep(input logic v);
    if (main_ok !== 1'b1) return;
    @(negedge clk);
    keep_wr = 1'b1;
    keep_wdata = v;
    @(negedge clk);
    keep_wr = 1'b0;
    keep_wdata = ~v;
  endtask : write_keep

  // ----------------------------------------------------------------
  // power-on line: level high or falling press is a turn-on
  // ----------------------------------------------------------------
  task automatic turn_on(input logic mode);
    power_on_pin = ~mode;
  endtask : turn_on

  task automatic release_pin(input logic mode);
    power_on_pin = mode;
  endtask : release_pin
endmodule : host_model
`default_nettype wire

// ===== tb.sv
`default_nettype none
module tb
  import startup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int B   = 20;
  localparam int TOL = 6;

  logic CLK = 1'b0, NRST = 1'b0, main = 1'b0, coin_ok = 1'b1, src = 1'b0, ce = 1'b1;
  logic fuse_req = 1'b0, ecc_en = 1'b0;
  logic [3:0] fuse_bits = 4'h0;
  logic [FUSE_W-1:0] fuse_word = '0, w, f;
  logic pin, kwr, kwd, swr;
  shadow_cfg_t swd, SHADOW_CFG, cfg;
  logic [N_BUCK-1:0] BUCK_EN;
  logic [N_LDO-1:0] LDO_EN;
  logic DDR_REF_EN, STANDBY_EN, OE, KEEP, ERR_FIX, ERR_MULTI, SEQ_BUSY, rst_out;
  logic [6:0] TARGET_ADDR;
  logic [N_OUT-1:0] en_vec, en_q = '0;
  int t_en [N_OUT];
  int cyc = 0, n_fail = 0, tests_run = 0, a;

  always #5 CLK = ~CLK;
  assign en_vec = {DDR_REF_EN, LDO_EN, BUCK_EN};
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    en_q <= en_vec;
    for (int i = 0; i < N_OUT; i++) if (en_vec[i] && !en_q[i]) t_en[i] = cyc;
  end

  host_model host_u (.clk(CLK), .main_ok(main), .power_on_pin(pin), .keep_wr(kwr), .keep_wdata(kwd),
                     .shadow_wr(swr), .shadow_wdata(swd));

  startup_sequencer #(.BASE_CYC(B), .LDO_FED(6'h01)) dut_u (
    .CLK(CLK), .NRST(NRST), .CE(ce), .MAIN_SUPPLY_VALID(main), .COIN_CELL_VALID(coin_ok),
    .CONFIG_SOURCE_PIN(src), .POWER_ON_PIN(pin), .KEEP_WR(kwr), .KEEP_WDATA(kwd), .SHADOW_WR(swr),
    .SHADOW_WDATA(swd), .FUSE_LOAD_REQUEST(fuse_req), .FUSE_LOAD_BITS(fuse_bits), .FUSE_ECC_EN(ecc_en),
    .FUSE_WORD(fuse_word), .BUCK_EN(BUCK_EN), .LDO_EN(LDO_EN), .DDR_REF_EN(DDR_REF_EN),
    .STANDBY_EN(STANDBY_EN), .HOST_RESET_N_OUT(rst_out), .HOST_RESET_N_OE(OE), .TARGET_ADDR(TARGET_ADDR),
    .SHADOW_CFG(SHADOW_CFG), .KEEP_SHADOW_FLAG(KEEP), .FUSE_ERR_FIXED(ERR_FIX),
    .FUSE_ERR_MULTI(ERR_MULTI), .SEQ_BUSY(SEQ_BUSY));

  // ----------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------
  function automatic int code_of(input shadow_cfg_t c, input int i);
    if (i < N_BUCK) return int'(c.buck_slot_code[i]);
    if (i < N_OUT - 1) return int'(c.ldo_slot_code[i-N_BUCK]);
    return int'(c.ddr_ref_slot_code);
  endfunction : code_of

  function automatic logic [CFG_W-1:0] fuse_data(input logic [FUSE_W-1:0] x);
    int j;
    j = 0;
    for (int p = 1; p < FUSE_W; p++) if ((p & (p - 1)) != 0) begin
      fuse_data[j] = x[p];
      j++;
    end
  endfunction : fuse_data

  function automatic logic [FUSE_W-1:0] fuse_enc(input logic [FUSE_W-1:0] x);
    for (int c = 1; c < FUSE_W; c = c * 2) begin
      x[c] = 1'b0;
      for (int p = 1; p < FUSE_W; p++) if (p != c && (p & c) != 0) x[c] ^= x[p];
    end
    x[0] = ^x[FUSE_W-1:1];
    return x;
  endfunction : fuse_enc

  function automatic shadow_cfg_t rand_cfg(input logic [1:0] sel, input logic mode);
    shadow_cfg_t c;
    c = shadow_cfg_t'({$urandom(), $urandom()});
    for (int i = 0; i < N_BUCK; i++) c.buck_slot_code[i] = SLOT_W'($urandom_range(7));
    for (int i = 0; i < N_LDO; i++) c.ldo_slot_code[i] = SLOT_W'($urandom_range(7));
    c.buck_slot_code[0] = SLOT_W'($urandom_range(6) + 1);
    c.ddr_ref_slot_code = (sel == 2'h0) ? 5'h1F : 5'h01;
    c.seq_tick_select = sel;
    c.button_mode_select = mode;
    return c;
  endfunction : rand_cfg

  // ----------------------------------------------------------------
  // compares and closing
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_time(input int got, input int exp, input int tol);
    tests_run++;
    if (got < exp - tol || got > exp + tol) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_time

  task automatic end_of_test;
    $display("checks=%0d failures=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // supply cycle and one start-up sequence
  // ----------------------------------------------------------------
  task automatic power_cycle(input logic coin);
    int n;
    @(negedge CLK);
    main = 1'b0;
    coin_ok = coin;
    repeat (6) @(negedge CLK);
    chk_val(en_vec, 0);
    chk_val(STANDBY_EN, 0);
    main = 1'b1;
    n = 0;
    while (STANDBY_EN !== 1'b1 && n < 2000) begin
      @(negedge CLK);
      n++;
    end
    if (n >= 2000) begin
      n_fail++;
      end_of_test();
    end
    // the base tick runs free, so the first tick lands anywhere within one unit
    chk_time(n, (coin ? STBY_COIN_US : STBY_NOCOIN_US) / BASE_TICK_US * B - B / 2 + 4, B / 2);
  endtask : power_cycle

  task automatic run_seq(input shadow_cfg_t c);
    int t0, mx, last, n, lim, e, s;
    mx = 0;
    s = int'(c.seq_tick_select);
    for (int i = 0; i < N_OUT; i++) begin
      t_en[i] = -1;
      if (code_of(c, i) > mx) mx = code_of(c, i);
    end
    lim = (FIRST_US[s] / 500 + mx * SLOT_US[s] / 500 + 8) * B;
    @(negedge CLK);
    t0 = cyc;
    host_u.turn_on(c.button_mode_select);
    n = 0;
    while (OE !== 1'b0 && n < lim) begin
      @(negedge CLK);
      n++;
    end
    if (mx == 0) begin
      chk_val({OE, en_vec}, {1'b1, 11'h000});
      return;
    end
    if (n >= lim) begin
      n_fail++;
      end_of_test();
    end
    for (int i = 0; i < N_OUT; i++) begin
      e = code_of(c, i);
      if (i == N_BUCK && e != 0 && code_of(c, 0) > e) e = code_of(c, 0);
      if (e == 0) chk_val(en_vec[i], 0);
      else chk_time(t_en[i], t0 + 2 + (FIRST_US[s] + (e - 1) * SLOT_US[s]) / 500 * B, TOL);
      if (e == mx) last = t_en[i];
      for (int j = 0; j < i; j++) if (e != 0 && e == code_of(c, j) && j != N_BUCK && i != N_BUCK)
        chk_val(64'(t_en[i] - t_en[j]), 0);
    end
    if (code_of(c, N_BUCK) != 0) chk_val(t_en[N_BUCK] >= t_en[0], 1);
    chk_time(cyc, last + 4 * B, TOL);
    chk_val(rst_out, 0);
    chk_val(SEQ_BUSY, 0);
  endtask : run_seq

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    a = $urandom(32'h6AB5);
    repeat (4) @(negedge CLK);
    NRST = 1'b1;
    chk_val({OE, en_vec, KEEP}, {1'b1, 11'h000, 1'b0});
    chk_val(SHADOW_CFG, 0);
    power_cycle(1'b0);
    // clock enable low: a supply dip must not be seen while frozen
    ce = 1'b0;
    main = 1'b0;
    repeat (8) @(negedge CLK);
    main = 1'b1;
    repeat (2) @(negedge CLK);
    chk_val({STANDBY_EN, OE}, 2'h3);
    ce = 1'b1;
    chk_val(SHADOW_CFG, 0);
    run_seq(SHADOW_CFG);
    host_u.release_pin(1'b0);
    fuse_req = 1'b1;
    fuse_bits = 4'hE;
    power_cycle(1'b1);
    chk_val(SHADOW_CFG, 0);
    fuse_bits = 4'hF;
    for (int k = 0; k < 3; k++) begin
      ecc_en = (k != 0);
      w = FUSE_W'({$urandom(), $urandom(), $urandom()});
      if (k > 0) w = fuse_enc(w);
      f = w;
      a = $urandom_range(67);
      if (k > 0) f[a] = ~f[a];
      if (k == 2) f[a+1] = ~f[a+1];
      fuse_word = f;
      power_cycle(1'b1);
      chk_val(SHADOW_CFG, fuse_data(k == 2 ? f : w));
      chk_val({ERR_MULTI, ERR_FIX}, k);
    end
    fuse_req = 1'b0;
    src = 1'b1;
    power_cycle(1'b1);
    chk_val(SHADOW_CFG, DEFAULT_CFG);
    chk_val(TARGET_ADDR, 7'h08);
    run_seq(DEFAULT_CFG);
    host_u.release_pin(1'b0);
    src = 1'b0;
    power_cycle(1'b1);
    host_u.write_keep(1'b1);
    chk_val(KEEP, 1);
    for (int k = 0; k < 4; k++) begin
      cfg = rand_cfg(k[1:0], k == 3);
      host_u.write_shadow(cfg);
      chk_val(SHADOW_CFG, cfg);
      if (k == 3) host_u.release_pin(1'b1);
      repeat (4) @(negedge CLK);
      run_seq(cfg);
      chk_val(SHADOW_CFG, cfg);
      chk_val(TARGET_ADDR, {4'h1, cfg.target_addr_bits});
      if (k < 3) begin
        host_u.release_pin(1'b0);
        repeat (6) @(negedge CLK);
        chk_val({OE, en_vec}, {1'b1, 11'h000});
      end
    end
    repeat (400) @(negedge CLK);
    chk_val(en_vec == '0, 0);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
